/* verilog/acrb_register_bank.sv */
// accelerometer user register bank behind the serial register port
// Function
// - z high byte shows sample bits 9:8 in bits 1:0, rest zero
// - read-only 8-bit byte per axis holding sample bits 7:0, zero g reads zero
// - status bit 0 is one when a new sample is ready
// - status bit 1 is one when a sample was overwritten unread
// - status bit 2 flags trim parity fault and forces self-test off
// - detection source bits 7,6,5 show x,y,z level hits
// - detection source bits 4,3,2 show x,y,z single tap hits
// - detection source bits 1,0 show second and first routed irq
// - address register bit 7 writable, bits 6:0 read-only address
// - disable bit one turns off the two-wire port
// - user info byte is read-only, zero or one-time-programmed
// - per-axis host-writable 11-bit signed offset trim, low byte plus three
// - trim bit 0 weighs half an LSB, doubling to bit 9, bit 10 sign
// - range field bits 3:2 select 8g, 2g or 4g
// - mode field bits 1:0 select standby, measure, level, tap
// - control bit 4 enables self-test
// - control bit 5 selects three-wire serial
// - control bit 6 masks sample ready from the first irq pin
// - low byte read latches high byte; host reads high right after
`timescale 1ns/1ps
module acrb_register_bank
    import acrb_pkg::*;
#(
    parameter logic [7:0] USER_INFO_VALUE = 8'h00,
    // arbitrary identity value
    parameter logic [7:0] IDENTITY_VALUE  = 8'h5a
)(
    input  wire logic                core_clk,
    input  wire logic                rst_b,
    input  wire logic                clkEn,
    input  wire logic [7:0]          regAddr,
    input  wire logic                regRead,
    input  wire logic                regWrite,
    input  wire logic [7:0]          regWriteData,
    output logic      [7:0]          regReadData,
    input  wire logic [SAMPLE_W-1:0] x_sample,
    input  wire logic [SAMPLE_W-1:0] y_sample,
    input  wire logic [SAMPLE_W-1:0] z_sample,
    input  wire logic                sample_ready_flag,
    input  wire logic                sample_overrun_flag,
    input  wire logic                trim_parity_fault,
    input  wire logic                x_level_hit,
    input  wire logic                y_level_hit,
    input  wire logic                z_level_hit,
    input  wire logic                x_tap_hit,
    input  wire logic                y_tap_hit,
    input  wire logic                z_tap_hit,
    input  wire logic                first_irq_flag,
    input  wire logic                second_irq_flag,
    output logic [TRIM_W-1:0]        x_offset_trim,
    output logic [TRIM_W-1:0]        y_offset_trim,
    output logic [TRIM_W-1:0]        z_offset_trim,
    output acrb_mode_t               opMode,
    output acrb_range_t              range_select,
    output logic                     self_check_enable,
    output logic                     three_wire_select,
    output logic                     ready_pin_mask,
    output logic                     readyToFirstPin,
    output logic                     two_wire_disable,
    output logic                     twoWireEnable,
    output logic [6:0]               bus_slave_address
);
    logic [CTRL_W-1:0] opCtrl;
    logic              disableBit;
    logic [1:0]        xHeld;
    logic [1:0]        yHeld;
    logic [1:0]        zHeld;
    logic [7:0]        next_readData;

    acrb_trim_if xTrimIf();
    acrb_trim_if yTrimIf();
    acrb_trim_if zTrimIf();

    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction

    wire wrCtrl  = regWrite && hit(regAddr, ADDR_OP_CTRL);
    wire wrAddr  = regWrite && hit(regAddr, ADDR_BUS_ADDR);
    wire rdXLow  = regRead && hit(regAddr, ADDR_X_LOW);
    wire rdYLow  = regRead && hit(regAddr, ADDR_Y_LOW);
    wire rdZLow  = regRead && hit(regAddr, ADDR_Z_LOW);

    assign xTrimIf.writeData = regWriteData;
    assign yTrimIf.writeData = regWriteData;
    assign zTrimIf.writeData = regWriteData;
    assign xTrimIf.writeLow  = regWrite && hit(regAddr, ADDR_X_OFF_LOW);
    assign xTrimIf.writeHigh = regWrite && hit(regAddr, ADDR_X_OFF_HIGH);
    assign yTrimIf.writeLow  = regWrite && hit(regAddr, ADDR_Y_OFF_LOW);
    assign yTrimIf.writeHigh = regWrite && hit(regAddr, ADDR_Y_OFF_HIGH);
    assign zTrimIf.writeLow  = regWrite && hit(regAddr, ADDR_Z_OFF_LOW);
    assign zTrimIf.writeHigh = regWrite && hit(regAddr, ADDR_Z_OFF_HIGH);

    acrb_offset_trim xTrim (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .clkEn    (clkEn),
        .port     (xTrimIf.store)
    );
    acrb_offset_trim yTrim (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .clkEn    (clkEn),
        .port     (yTrimIf.store)
    );
    acrb_offset_trim zTrim (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .clkEn    (clkEn),
        .port     (zTrimIf.store)
    );

    // trims feed the datapath; weights are typical, bit 0 is half an LSB
    assign x_offset_trim = xTrimIf.trim;
    assign y_offset_trim = yTrimIf.trim;
    assign z_offset_trim = zTrimIf.trim;

    acrb_sample_latch xLatch (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .clkEn    (clkEn),
        .sample   (x_sample),
        .lowRead  (rdXLow),
        .heldHigh (xHeld)
    );
    acrb_sample_latch yLatch (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .clkEn    (clkEn),
        .sample   (y_sample),
        .lowRead  (rdYLow),
        .heldHigh (yHeld)
    );
    acrb_sample_latch zLatch (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .clkEn    (clkEn),
        .sample   (z_sample),
        .lowRead  (rdZLow),
        .heldHigh (zHeld)
    );

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            opCtrl     <= RST_OP_CTRL;
            disableBit <= 1'b0;
        end else if (clkEn) begin
            if (wrCtrl) begin
                opCtrl <= regWriteData[CTRL_W-1:0];
            end
            if (wrAddr) begin
                disableBit <= regWriteData[POS_DISABLE];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            regReadData <= 8'h00;
        end else if (clkEn && regRead) begin
            regReadData <= next_readData;
        end
    end

    assign opMode            = acrb_mode_t'(opCtrl[1:0]);
    assign range_select      = acrb_range_t'(opCtrl[3:2]);
    // parity fault in trim data overrides the host's self-test request
    assign self_check_enable = opCtrl[POS_SELF_CHECK]
                               && !trim_parity_fault;
    assign three_wire_select = opCtrl[POS_THREE_WIRE];
    assign ready_pin_mask    = opCtrl[POS_READY_MASK];
    assign readyToFirstPin   = sample_ready_flag
                               && !opCtrl[POS_READY_MASK];
    assign two_wire_disable  = disableBit;
    assign twoWireEnable     = !disableBit;
    assign bus_slave_address = RST_BUS_ADDR;

    wire [7:0] statusByte = {5'h00,
                             trim_parity_fault,
                             sample_overrun_flag,
                             sample_ready_flag};
    // tap flags pass through; their meaning in double-tap mode is the host's
    wire [7:0] detSrcByte = {x_level_hit, y_level_hit, z_level_hit,
                             x_tap_hit, y_tap_hit, z_tap_hit,
                             second_irq_flag, first_irq_flag};

    always_comb begin
        if (hit(regAddr, ADDR_X_LOW)) begin
            next_readData = x_sample[7:0];
        end else if (hit(regAddr, ADDR_X_HIGH)) begin
            next_readData = {6'h00, xHeld};
        end else if (hit(regAddr, ADDR_Y_LOW)) begin
            next_readData = y_sample[7:0];
        end else if (hit(regAddr, ADDR_Y_HIGH)) begin
            next_readData = {6'h00, yHeld};
        end else if (hit(regAddr, ADDR_Z_LOW)) begin
            next_readData = z_sample[7:0];
        end else if (hit(regAddr, ADDR_Z_HIGH)) begin
            next_readData = {6'h00, zHeld};
        end else if (hit(regAddr, ADDR_X_BYTE)) begin
            next_readData = x_sample[7:0];
        end else if (hit(regAddr, ADDR_Y_BYTE)) begin
            next_readData = y_sample[7:0];
        end else if (hit(regAddr, ADDR_Z_BYTE)) begin
            next_readData = z_sample[7:0];
        end else if (hit(regAddr, ADDR_STATUS)) begin
            next_readData = statusByte;
        end else if (hit(regAddr, ADDR_DET_SRC)) begin
            next_readData = detSrcByte;
        end else if (hit(regAddr, ADDR_BUS_ADDR)) begin
            next_readData = {disableBit, RST_BUS_ADDR};
        end else if (hit(regAddr, ADDR_USER_INFO)) begin
            next_readData = USER_INFO_VALUE;
        end else if (hit(regAddr, ADDR_IDENTITY)) begin
            next_readData = IDENTITY_VALUE;
        end else if (hit(regAddr, ADDR_X_OFF_LOW)) begin
            next_readData = xTrimIf.trim[7:0];
        end else if (hit(regAddr, ADDR_X_OFF_HIGH)) begin
            next_readData = {5'h00, xTrimIf.trim[TRIM_W-1:8]};
        end else if (hit(regAddr, ADDR_Y_OFF_LOW)) begin
            next_readData = yTrimIf.trim[7:0];
        end else if (hit(regAddr, ADDR_Y_OFF_HIGH)) begin
            next_readData = {5'h00, yTrimIf.trim[TRIM_W-1:8]};
        end else if (hit(regAddr, ADDR_Z_OFF_LOW)) begin
            next_readData = zTrimIf.trim[7:0];
        end else if (hit(regAddr, ADDR_Z_OFF_HIGH)) begin
            next_readData = {5'h00, zTrimIf.trim[TRIM_W-1:8]};
        end else if (hit(regAddr, ADDR_OP_CTRL)) begin
            next_readData = {1'b0, opCtrl};
        end else begin
            next_readData = 8'h00;
        end
    end
endmodule

/* verilog/acrb_pkg.sv */
// register map, field positions and reset values of the accel register bank
package acrb_pkg;
    localparam logic [7:0] ADDR_X_LOW      = 8'h00;
    localparam logic [7:0] ADDR_X_HIGH     = 8'h01;
    localparam logic [7:0] ADDR_Y_LOW      = 8'h02;
    localparam logic [7:0] ADDR_Y_HIGH     = 8'h03;
    localparam logic [7:0] ADDR_Z_LOW      = 8'h04;
    localparam logic [7:0] ADDR_Z_HIGH     = 8'h05;
    localparam logic [7:0] ADDR_X_BYTE     = 8'h06;
    localparam logic [7:0] ADDR_Y_BYTE     = 8'h07;
    localparam logic [7:0] ADDR_Z_BYTE     = 8'h08;
    localparam logic [7:0] ADDR_STATUS     = 8'h09;
    localparam logic [7:0] ADDR_DET_SRC    = 8'h0a;
    localparam logic [7:0] ADDR_BUS_ADDR   = 8'h0d;
    localparam logic [7:0] ADDR_USER_INFO  = 8'h0e;
    localparam logic [7:0] ADDR_IDENTITY   = 8'h0f;
    localparam logic [7:0] ADDR_X_OFF_LOW  = 8'h10;
    localparam logic [7:0] ADDR_X_OFF_HIGH = 8'h11;
    localparam logic [7:0] ADDR_Y_OFF_LOW  = 8'h12;
    localparam logic [7:0] ADDR_Y_OFF_HIGH = 8'h13;
    localparam logic [7:0] ADDR_Z_OFF_LOW  = 8'h14;
    localparam logic [7:0] ADDR_Z_OFF_HIGH = 8'h15;
    localparam logic [7:0] ADDR_OP_CTRL    = 8'h16;

    localparam int         SAMPLE_W        = 10;
    localparam int         TRIM_W          = 11;
    localparam int         TRIM_HIGH_W     = 3;
    localparam int         CTRL_W          = 7;

    localparam int         POS_READY       = 0;
    localparam int         POS_OVERRUN     = 1;
    localparam int         POS_PARITY      = 2;
    localparam int         POS_DISABLE     = 7;
    localparam int         POS_SELF_CHECK  = 4;
    localparam int         POS_THREE_WIRE  = 5;
    localparam int         POS_READY_MASK  = 6;

    localparam logic [6:0] RST_BUS_ADDR    = 7'h1d;
    localparam logic [6:0] RST_OP_CTRL     = 7'h00;
    localparam logic [7:0] RST_TRIM_BYTE   = 8'h00;

    typedef enum logic [1:0] {
        ACRB_STANDBY,
        ACRB_MEASURE,
        ACRB_LEVEL,
        ACRB_TAP
    } acrb_mode_t;

    typedef enum logic [1:0] {
        ACRB_RANGE_8G,
        ACRB_RANGE_2G,
        ACRB_RANGE_4G,
        ACRB_RANGE_RSVD
    } acrb_range_t;
endpackage

/* verilog/acrb_trim_if.sv */
// carrier between the bank and its per-axis offset trim store
`timescale 1ns/1ps
interface acrb_trim_if;
    import acrb_pkg::*;
    logic              writeLow;
    logic              writeHigh;
    logic [7:0]        writeData;
    logic [TRIM_W-1:0] trim;
    modport bank  (output writeLow, output writeHigh, output writeData,
                   input trim);
    modport store (input writeLow, input writeHigh, input writeData,
                   output trim);
endinterface

/* verilog/acrb_offset_trim.sv */
// one axis of 11-bit host-writable offset trim, low byte plus three high bits
`timescale 1ns/1ps
module acrb_offset_trim
    import acrb_pkg::*;
(
    input  wire logic  core_clk,
    input  wire logic  rst_b,
    input  wire logic  clkEn,
    acrb_trim_if.store port
);
    logic [7:0]             lowByte;
    logic [TRIM_HIGH_W-1:0] highBits;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            lowByte  <= RST_TRIM_BYTE;
            highBits <= RST_TRIM_BYTE[TRIM_HIGH_W-1:0];
        end else if (clkEn) begin
            if (port.writeLow) begin
                lowByte <= port.writeData;
            end
            // upper five bits of the high byte are dropped
            if (port.writeHigh) begin
                highBits <= port.writeData[TRIM_HIGH_W-1:0];
            end
        end
    end

    assign port.trim = {highBits, lowByte};
endmodule

/* verilog/acrb_sample_latch.sv */
// holds an axis high part when its low byte is read, for coherent 10-bit reads
`timescale 1ns/1ps
module acrb_sample_latch
    import acrb_pkg::*;
(
    input  wire logic                core_clk,
    input  wire logic                rst_b,
    input  wire logic                clkEn,
    input  wire logic [SAMPLE_W-1:0] sample,
    input  wire logic                lowRead,
    output logic      [1:0]          heldHigh
);
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            heldHigh <= 2'h0;
        end else if (clkEn && lowRead) begin
            heldHigh <= sample[SAMPLE_W-1:8];
        end
    end
endmodule

/* verification/acrb_assertions.sv */
// port assertions for the accel register bank
`timescale 1ns/1ps
module acrb_assertions
    import acrb_pkg::*;
(
    input wire logic                core_clk,
    input wire logic                rst_b,
    input wire logic                clkEn,
    input wire logic [7:0]          regAddr,
    input wire logic                regRead,
    input wire logic                regWrite,
    input wire logic [7:0]          regWriteData,
    input wire logic [7:0]          regReadData,
    input wire logic [SAMPLE_W-1:0] z_sample,
    input wire logic                sample_ready_flag,
    input wire logic                sample_overrun_flag,
    input wire logic                trim_parity_fault,
    input wire logic [TRIM_W-1:0]   x_offset_trim,
    input wire acrb_mode_t          opMode,
    input wire acrb_range_t         range_select,
    input wire logic                three_wire_select,
    input wire logic                ready_pin_mask,
    input wire logic                self_check_enable,
    input wire logic                readyToFirstPin,
    input wire logic                two_wire_disable,
    input wire logic                twoWireEnable,
    input wire logic [6:0]          bus_slave_address
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    wire rdOk = regRead && clkEn;
    wire wrOk = regWrite && clkEn;
    sequence s_z_low; rdOk && regAddr == ADDR_Z_LOW; endsequence
    sequence s_z_high; rdOk && regAddr == ADDR_Z_HIGH; endsequence
    a_z_coherent: assert property (s_z_low ##1 s_z_high |=>
        regReadData == {6'h00, $past(z_sample[9:8], 2)})
        else $error("z high byte not held from low read");
    a_z_byte: assert property (rdOk && regAddr == ADDR_Z_BYTE |=>
        regReadData == $past(z_sample[7:0]))
        else $error("z byte read wrong");
    a_status_bits: assert property (rdOk && regAddr == ADDR_STATUS |=>
        regReadData == {5'h00, $past(trim_parity_fault),
        $past(sample_overrun_flag), $past(sample_ready_flag)})
        else $error("status read wrong");
    a_self_gate: assert property (trim_parity_fault |-> !self_check_enable)
        else $error("self-test on during parity fault");
    a_ready_route: assert property (readyToFirstPin ==
        (sample_ready_flag && !ready_pin_mask)) else $error("ready pin wrong");
    a_bus_enable: assert property (twoWireEnable != two_wire_disable)
        else $error("two-wire enable not inverse of disable");
    a_addr_fixed: assert property (rdOk && regAddr == ADDR_BUS_ADDR
        |=> regReadData == {$past(two_wire_disable), 7'h1d}
        && bus_slave_address == 7'h1d)
        else $error("bus address read wrong");
    a_ctrl_write: assert property (wrOk && regAddr == ADDR_OP_CTRL |=>
        opMode == $past(regWriteData[1:0]) && range_select ==
        $past(regWriteData[3:2]) && three_wire_select == $past(regWriteData[5])
        && ready_pin_mask == $past(regWriteData[6])) else $error("ctrl wrong");
    a_trim_low: assert property (wrOk && regAddr == ADDR_X_OFF_LOW |=>
        x_offset_trim[7:0] == $past(regWriteData)) else $error("trim wrong");
endmodule
bind acrb_register_bank acrb_assertions u_chk (.core_clk, .rst_b, .clkEn,
    .regAddr, .regRead, .regWrite, .regWriteData, .regReadData, .z_sample,
    .sample_ready_flag, .sample_overrun_flag, .trim_parity_fault,
    .x_offset_trim, .opMode, .range_select, .three_wire_select,
    .ready_pin_mask, .self_check_enable, .readyToFirstPin,
    .two_wire_disable, .twoWireEnable, .bus_slave_address);

/* verification/acrb_sensor_model.sv */
// measurement datapath model feeding samples to the bank
`timescale 1ns/1ps
module acrb_sensor_model
    import acrb_pkg::*;
(
    input  wire logic                core_clk,
    input  wire logic                rst_b,
    input  wire logic                run,
    output logic      [SAMPLE_W-1:0] x_sample,
    output logic      [SAMPLE_W-1:0] y_sample,
    output logic      [SAMPLE_W-1:0] z_sample
);
    logic [SAMPLE_W-1:0] count;
    // upper bits move every cycle so a stale high byte shows at once
    always @(negedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= 10'h000;
        end else if (run) begin
            count <= count + 10'h101;
        end
    end
    assign x_sample = count;
    assign y_sample = ~count;
    assign z_sample = count ^ 10'h2a5;
endmodule

/* verification/tb_top.sv */
// self-checking bench for the accel register bank
`timescale 1ns/1ps
module tb_top;
    import acrb_pkg::*;
    logic                core_clk = 1'b0;
    logic                rst_b = 1'b0;
    logic                clkEn = 1'b1;
    logic                run = 1'b0;
    logic                regRead = 1'b0;
    logic                regWrite = 1'b0;
    logic [7:0]          regAddr = 8'h00;
    logic [7:0]          regWriteData = 8'h00;
    logic [2:0]          stat = 3'h0;
    logic [7:0]          det = 8'h00;
    logic [7:0]          regReadData, d;
    logic [SAMPLE_W-1:0] x_sample, y_sample, z_sample, held;
    logic [SAMPLE_W-1:0] snap [3];
    logic [TRIM_W-1:0]   x_offset_trim, y_offset_trim, z_offset_trim;
    acrb_mode_t          opMode;
    acrb_range_t         range_select;
    logic                self_check_enable, three_wire_select;
    logic                ready_pin_mask, readyToFirstPin;
    logic                two_wire_disable, twoWireEnable;
    logic [6:0]          bus_slave_address;
    logic [7:0]          ta [8] = '{8'h05, 8'h09, 8'h0c, 8'h0d,
                                    8'h0e, 8'h10, 8'h11, 8'h16};
    logic [7:0]          tr [8] = '{0, 0, 0, 8'h1d, 8'h3c, 0, 0, 0};
    logic [7:0]          tw [8] = '{0, 0, 0, 8'h9d, 8'h3c, 8'hff, 7, 8'h7f};
    int                  failures = 0;
    int                  num_checks = 0;

    always #25 core_clk = ~core_clk;

    acrb_register_bank #(.USER_INFO_VALUE(8'h3c)) DUT (
        .core_clk, .rst_b, .clkEn, .regAddr, .regRead, .regWrite,
        .regWriteData, .regReadData, .x_sample, .y_sample, .z_sample,
        .sample_ready_flag(stat[0]), .sample_overrun_flag(stat[1]),
        .trim_parity_fault(stat[2]), .x_level_hit(det[7]),
        .y_level_hit(det[6]), .z_level_hit(det[5]), .x_tap_hit(det[4]),
        .y_tap_hit(det[3]), .z_tap_hit(det[2]), .second_irq_flag(det[1]),
        .first_irq_flag(det[0]), .x_offset_trim, .y_offset_trim,
        .z_offset_trim, .opMode, .range_select, .self_check_enable,
        .three_wire_select, .ready_pin_mask, .readyToFirstPin,
        .two_wire_disable, .twoWireEnable, .bus_slave_address);
    acrb_sensor_model u_sens (.core_clk, .rst_b, .run, .x_sample,
        .y_sample, .z_sample);

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        num_checks++;
        if (seen !== want) begin
            failures++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, want);
        end
    endtask

    // entered at a falling edge; one access per cycle, strobes stay up
    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [7:0] wd, output logic [7:0] rd);
        regAddr = a;
        regWriteData = wd;
        regWrite = w;
        regRead = !w;
        @(posedge core_clk);
        snap = '{x_sample, y_sample, z_sample};
        @(negedge core_clk);
        rd = regReadData;
    endtask

    task automatic complete_run;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (2000) @(posedge core_clk);
        failures++;
        complete_run();
    end

    initial begin
        repeat (10) @(negedge core_clk);
        rst_b = 1'b1;
        check({opMode, range_select, self_check_enable, ready_pin_mask}, 0);
        for (int i = 0; i < 8; i++) begin
            acc(0, ta[i], 8'h00, d);
            check(d, tr[i]);
            acc(1, ta[i], 8'hff, d);
            acc(0, ta[i], 8'h00, d);
            check(d, tw[i]);
        end
        check({two_wire_disable, twoWireEnable, bus_slave_address}, 9'h11d);
        $display("register access done");
        acc(1, ADDR_X_OFF_LOW, 8'ha5, d);
        acc(1, ADDR_X_OFF_HIGH, 8'hfe, d);
        acc(1, ADDR_Y_OFF_LOW, 8'h3c, d);
        acc(1, ADDR_Y_OFF_HIGH, 8'h03, d);
        acc(1, ADDR_Z_OFF_LOW, 8'h00, d);
        acc(1, ADDR_Z_OFF_HIGH, 8'h04, d);
        check(x_offset_trim, 11'h6a5);
        check(y_offset_trim, 11'h33c);
        check(z_offset_trim, 11'h400);
        // a write seen while the clock enable is low must be dropped
        clkEn = 1'b0;
        acc(1, ADDR_Z_OFF_LOW, 8'h77, d);
        clkEn = 1'b1;
        check(z_offset_trim, 11'h400);
        for (int i = 0; i < 16; i++) begin
            acc(1, ADDR_OP_CTRL, 8'(i), d);
            check(opMode, 16'(i % 4));
            check(range_select, 16'(i / 4));
        end
        $display("trim and mode done");
        // measure-mode setup; the tap flags pass through to the host whatever the mode
        acc(1, ADDR_OP_CTRL, 8'h01, d);
        for (int i = 0; i < 8; i++) begin
            stat = 3'(1 << i);
            det = 8'(1 << i);
            acc(0, ADDR_STATUS, 8'h00, d);
            check(d, 16'(stat));
            acc(0, ADDR_DET_SRC, 8'h00, d);
            check(d, 16'(det));
        end
        acc(1, ADDR_OP_CTRL, 8'h30, d);
        stat = 3'h1;
        @(negedge core_clk);
        check({self_check_enable, three_wire_select, readyToFirstPin},
              7);
        stat = 3'h5;
        @(negedge core_clk);
        check({self_check_enable, readyToFirstPin}, 2'h1);
        acc(1, ADDR_OP_CTRL, 8'h50, d);
        check({three_wire_select, ready_pin_mask, readyToFirstPin}, 2);
        $display("flags done");
        run = 1'b1;
        for (int k = 0; k < 3; k++) begin
            acc(0, 8'(2 * k), 8'h00, d);
            held = snap[k];
            check(d, 16'(held[7:0]));
            acc(0, 8'(2 * k + 1), 8'h00, d);
            check(d, {6'h00, held[9:8]});
            acc(0, 8'(6 + k), 8'h00, d);
            check(d, 16'(snap[k][7:0]));
        end
        rst_b = 1'b0;
        @(negedge core_clk);
        rst_b = 1'b1;
        acc(0, ADDR_OP_CTRL, 8'h00, d);
        check(d, 0);
        check(x_offset_trim, 0);
        $display("sample reads and reset done");
        complete_run();
    end
endmodule
